// ---- design/lsr_pkg.sv ----
// shared constants and types of the limit status register block
package lsr_pkg;

    // ****************************************************************
    // bus shape
    // ****************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_CHANNEL_LIMIT_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_INTERNAL_TEMPERATURE_VALUE = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_MEASUREMENT_CONFIG = 8'h28;
    localparam logic [1:0] WORD_ALIGN_BITS = 2'h0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [REG_W-1:0] RST_CHANNEL_LIMIT_STATUS = 8'h00;
    localparam logic [REG_W-1:0] RST_INTERNAL_TEMPERATURE_VALUE = 8'h00;
    localparam logic [REG_W-1:0] RST_MEASUREMENT_CONFIG = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned BIT_REMOTE_DIODE_ONE = 0;
    localparam int unsigned BIT_REMOTE_DIODE_TWO = 1;
    localparam int unsigned BIT_STANDBY_SUPPLY = 2;
    localparam int unsigned BIT_VOLTAGE_MODE = 0;
    localparam logic [REG_W-1:0] MASK_STATUS_USED = 8'h07;
    localparam logic [REG_W-1:0] MASK_CONFIG_USED = 8'h01;

    // ****************************************************************
    // bus answers
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        LSR_REG_STATUS = 2'h0,
        LSR_REG_TEMP = 2'h1,
        LSR_REG_CONFIG = 2'h2,
        LSR_REG_NONE = 2'h3
    } lsr_reg_type;

endpackage

// ---- design/lsr_core_if.sv ----
// bundle between the bus front end and the status core
interface lsr_core_if;
    logic conversion_done;
    logic [lsr_pkg::REG_W-1:0] temperature_sample;
    logic remote_diode_one_out_of_limit;
    logic remote_diode_two_out_of_limit;
    logic analog_input_nine_out_of_limit;
    logic standby_supply_out_of_limit;
    logic remote_diode_one_override_event;
    logic remote_diode_two_override_event;
    logic voltage_mode;
    logic [lsr_pkg::REG_W-1:0] channel_limit_status;
    logic [lsr_pkg::REG_W-1:0] internal_temperature_value;

    modport core (
        input conversion_done, temperature_sample,
        input remote_diode_one_out_of_limit, remote_diode_two_out_of_limit,
        input analog_input_nine_out_of_limit, standby_supply_out_of_limit,
        input remote_diode_one_override_event, remote_diode_two_override_event,
        input voltage_mode,
        output channel_limit_status, internal_temperature_value
    );

    modport front (
        output conversion_done, temperature_sample,
        output remote_diode_one_out_of_limit, remote_diode_two_out_of_limit,
        output analog_input_nine_out_of_limit, standby_supply_out_of_limit,
        output remote_diode_one_override_event, remote_diode_two_override_event,
        output voltage_mode,
        input channel_limit_status, internal_temperature_value
    );
endinterface

// ---- design/lsr_status_core.sv ----
// status and temperature holding registers updated per conversion cycle
module lsr_status_core (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // measurement side
    lsr_core_if.core core
);

    // ****************************************************************
    // next status value
    // ****************************************************************
    logic [lsr_pkg::REG_W-1:0] limit_flags;
    logic [lsr_pkg::REG_W-1:0] override_flags;
    logic [lsr_pkg::REG_W-1:0] status_d;
    logic [lsr_pkg::REG_W-1:0] status_q;
    logic [lsr_pkg::REG_W-1:0] temp_q;

    always_comb begin
        limit_flags = '0;
        limit_flags[lsr_pkg::BIT_REMOTE_DIODE_ONE] = core.remote_diode_one_out_of_limit; // see R3
        // voltage mode swaps the second diode for the ninth analog input
        limit_flags[lsr_pkg::BIT_REMOTE_DIODE_TWO] = core.voltage_mode ?
            core.analog_input_nine_out_of_limit : core.remote_diode_two_out_of_limit; // see R6
        limit_flags[lsr_pkg::BIT_STANDBY_SUPPLY] = core.standby_supply_out_of_limit; // see R9
    end

    always_comb begin
        override_flags = '0;
        override_flags[lsr_pkg::BIT_REMOTE_DIODE_ONE] = core.remote_diode_one_override_event; // see R4 see R5
        override_flags[lsr_pkg::BIT_REMOTE_DIODE_TWO] = core.remote_diode_two_override_event; // see R7 see R8
    end

    // one-shot sets survive until the next conversion replaces them;
    // a set landing on that same edge still wins
    always_comb begin
        if (core.conversion_done) begin
            status_d = limit_flags | override_flags; // see R10
        end else begin
            status_d = status_q | override_flags; // see R10
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= lsr_pkg::RST_CHANNEL_LIMIT_STATUS; // see R2
        end else begin
            status_q <= status_d & lsr_pkg::MASK_STATUS_USED;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temp_q <= lsr_pkg::RST_INTERNAL_TEMPERATURE_VALUE; // see R1
        end else if (core.conversion_done) begin
            temp_q <= core.temperature_sample; // see R1
        end
    end

    assign core.channel_limit_status = status_q;
    assign core.internal_temperature_value = temp_q;

endmodule

// ---- design/lsr_top.sv ----
// limit status register bank with its AXI4-Lite register slave
//
// What this block does
// R1: an 8-bit read-only register holds the latest internal temperature and powers up at zero.
// R2: a read-only channel status register sits at 20h and powers up with all bits zero.
// R3: status bit 0 shows whether the first remote diode was outside its limits on the last conversion.
// R4: bit 0 is set once when thermal override mode engages because of the first remote diode.
// R5: bit 0 is set once when thermal override mode disengages for the first diode 5 degrees below its limit.
// R6: status bit 1 shows the second remote diode limit result, or the ninth analog input in voltage mode.
// R7: bit 1 is set once when thermal override mode engages because of the second remote diode.
// R8: bit 1 is set once when thermal override mode disengages for the second diode 5 degrees below its limit.
// R9: the standby supply status bit shows whether that supply was outside its limits on the last conversion.
// R10: a one-shot override set holds until the next conversion, which replaces it with the limit result.
//
// Local design decision: register access over AXI4-Lite.
module lsr_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [lsr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [lsr_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [lsr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [lsr_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // conversion results, same clock
    input wire logic conversion_done,
    input wire logic [lsr_pkg::REG_W-1:0] temperature_sample,
    input wire logic remote_diode_one_out_of_limit,
    input wire logic remote_diode_two_out_of_limit,
    input wire logic analog_input_nine_out_of_limit,
    input wire logic standby_supply_out_of_limit,
    // thermal override mode transitions, one pulse each
    input wire logic remote_diode_one_override_event,
    input wire logic remote_diode_two_override_event,
    // mode seen by the converter
    output logic voltage_mode
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic lsr_pkg::lsr_reg_type lsr_decode(input logic [lsr_pkg::ADDR_W-1:0] addr);
        lsr_pkg::lsr_reg_type sel;
        sel = lsr_pkg::LSR_REG_NONE;
        if (addr[1:0] == lsr_pkg::WORD_ALIGN_BITS) begin
            case (addr)
                lsr_pkg::OFS_CHANNEL_LIMIT_STATUS: sel = lsr_pkg::LSR_REG_STATUS;
                lsr_pkg::OFS_INTERNAL_TEMPERATURE_VALUE: sel = lsr_pkg::LSR_REG_TEMP;
                lsr_pkg::OFS_MEASUREMENT_CONFIG: sel = lsr_pkg::LSR_REG_CONFIG;
                default: sel = lsr_pkg::LSR_REG_NONE;
            endcase
        end
        return sel;
    endfunction

    // ****************************************************************
    // status core
    // ****************************************************************
    lsr_core_if core_bus ();

    logic [lsr_pkg::REG_W-1:0] config_q;

    assign core_bus.conversion_done = conversion_done;
    assign core_bus.temperature_sample = temperature_sample;
    assign core_bus.remote_diode_one_out_of_limit = remote_diode_one_out_of_limit;
    assign core_bus.remote_diode_two_out_of_limit = remote_diode_two_out_of_limit;
    assign core_bus.analog_input_nine_out_of_limit = analog_input_nine_out_of_limit;
    assign core_bus.standby_supply_out_of_limit = standby_supply_out_of_limit;
    assign core_bus.remote_diode_one_override_event = remote_diode_one_override_event;
    assign core_bus.remote_diode_two_override_event = remote_diode_two_override_event;
    assign core_bus.voltage_mode = config_q[lsr_pkg::BIT_VOLTAGE_MODE]; // see R6

    lsr_status_core u_core (
        .aclk(aclk),
        .aresetn(aresetn),
        .core(core_bus.core)
    );

    // ****************************************************************
    // write channel
    // ****************************************************************
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_held_q;
    logic w_held_q;
    logic [lsr_pkg::ADDR_W-1:0] waddr_q;
    logic [lsr_pkg::REG_W-1:0] wdata_q;
    logic wstrb0_q;
    logic aw_take;
    logic w_take;
    logic write_go;
    lsr_pkg::lsr_reg_type wsel;

    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take = s_axi_wvalid && wready_q;
    // address and data may come in either order; the write commits once both are in
    assign write_go = aw_held_q && w_held_q && !bvalid_q;
    assign wsel = lsr_decode(waddr_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
        end else if (bvalid_q && s_axi_bready) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
        end else if (bvalid_q && s_axi_bready) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waddr_q <= '0;
        end else if (aw_take) begin
            waddr_q <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else if (w_take) begin
            wdata_q <= s_axi_wdata[lsr_pkg::REG_W-1:0];
            wstrb0_q <= s_axi_wstrb[0];
        end
    end

    // the measurement registers refuse writes with slverr, holes get decerr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= lsr_pkg::RESP_OKAY;
        end else if (write_go) begin
            bvalid_q <= 1'b1;
            case (wsel)
                lsr_pkg::LSR_REG_CONFIG: bresp_q <= lsr_pkg::RESP_OKAY;
                lsr_pkg::LSR_REG_STATUS: bresp_q <= lsr_pkg::RESP_SLVERR; // see R2
                lsr_pkg::LSR_REG_TEMP: bresp_q <= lsr_pkg::RESP_SLVERR; // see R1
                default: bresp_q <= lsr_pkg::RESP_DECERR;
            endcase
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_q <= lsr_pkg::RST_MEASUREMENT_CONFIG;
        end else if (write_go && wsel == lsr_pkg::LSR_REG_CONFIG && wstrb0_q) begin
            config_q <= wdata_q & lsr_pkg::MASK_CONFIG_USED;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            voltage_mode <= 1'b0;
        end else begin
            voltage_mode <= config_q[lsr_pkg::BIT_VOLTAGE_MODE];
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    logic arready_q;
    logic rvalid_q;
    logic [lsr_pkg::DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic ar_take;
    lsr_pkg::lsr_reg_type rsel;

    assign ar_take = s_axi_arvalid && arready_q;
    assign rsel = lsr_decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // data is snapshot on the address edge so it stands still while rvalid waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= '0;
            rresp_q <= lsr_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rdata_q <= '0;
            rresp_q <= lsr_pkg::RESP_OKAY;
            case (rsel)
                lsr_pkg::LSR_REG_STATUS: rdata_q[lsr_pkg::REG_W-1:0] <= core_bus.channel_limit_status; // see R2
                lsr_pkg::LSR_REG_TEMP: rdata_q[lsr_pkg::REG_W-1:0] <= core_bus.internal_temperature_value; // see R1
                lsr_pkg::LSR_REG_CONFIG: rdata_q[lsr_pkg::REG_W-1:0] <= config_q;
                default: rresp_q <= lsr_pkg::RESP_DECERR;
            endcase
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule

// ---- testbench/lsr_top_asserts.sv ----
// assertion checker for the limit status register bank, bound to its top
module lsr_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // measurement side
    input wire logic conversion_done,
    input wire logic [7:0] temperature_sample,
    input wire logic remote_diode_one_out_of_limit,
    input wire logic standby_supply_out_of_limit,
    input wire logic remote_diode_one_override_event
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic st0_q;
    logic st2_q;
    logic [7:0] temp_q;
    logic wr_take;
    logic rd_take;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    // ************************************************
    // reference copy of bits free of voltage mode
    // ************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st0_q <= 1'b0;
            st2_q <= 1'b0;
            temp_q <= 8'h00;
        end else if (conversion_done) begin
            st0_q <= remote_diode_one_out_of_limit || remote_diode_one_override_event;
            st2_q <= standby_supply_out_of_limit;
            temp_q <= temperature_sample;
        end else if (remote_diode_one_override_event) begin
            st0_q <= 1'b1;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
        s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid) else $error("bus not idle after reset");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
    a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    a_ro_write: assert property (wr_take && s_axi_awaddr == 8'h20 |-> ##2
        s_axi_bresp == lsr_pkg::RESP_SLVERR) else $error("status write accepted");
    a_status_read: assert property (rd_take && s_axi_araddr == 8'h20 |=>
        s_axi_rdata[0] == $past(st0_q) && s_axi_rdata[2] == $past(st2_q) && s_axi_rdata[7:3] == 5'h00)
        else $error("status read wrong");
    a_temp_read: assert property (rd_take && s_axi_araddr == 8'h24 |=>
        s_axi_rdata[7:0] == $past(temp_q)) else $error("temperature read wrong");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    c_override: cover property (remote_diode_one_override_event && !conversion_done);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == lsr_pkg::RESP_SLVERR);
    c_decerr: cover property (s_axi_rvalid && s_axi_rresp == lsr_pkg::RESP_DECERR);
endmodule

bind lsr_top lsr_asserts i_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .conversion_done, .temperature_sample,
    .remote_diode_one_out_of_limit, .standby_supply_out_of_limit, .remote_diode_one_override_event
);

// ---- testbench/tb.sv ----
// self-checking bench for the limit status register bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, voltage_mode, conversion_done;
    logic [7:0] s_axi_awaddr, s_axi_araddr, temperature_sample;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic remote_diode_one_out_of_limit, remote_diode_two_out_of_limit;
    logic analog_input_nine_out_of_limit, standby_supply_out_of_limit;
    logic remote_diode_one_override_event, remote_diode_two_override_event;
    int error_cnt;
    int comparisons;

    lsr_top i_dut (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .conversion_done, .temperature_sample,
        .remote_diode_one_out_of_limit, .remote_diode_two_out_of_limit, .analog_input_nine_out_of_limit,
        .standby_supply_out_of_limit, .remote_diode_one_override_event, .remote_diode_two_override_event,
        .voltage_mode
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ************************************************
    // tasks
    // ************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er, input int hold = 0);
        int n;
        n = 0;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_bready <= (hold == 0);
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
            // a late bready keeps the answer waiting so its hold gets watched
            if (n == hold + 1) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && n < 50);
        check(32'(s_axi_bvalid), 32'h1, "write answer");
        check(32'(s_axi_bresp), 32'(er), "write response");
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er, input int hold = 0);
        int n;
        n = 0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= (hold == 0);
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
            if (n == hold + 1) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 50);
        check(32'(s_axi_rvalid), 32'h1, "read answer");
        check(s_axi_rdata, {24'h000000, d}, "read data");
        check(32'(s_axi_rresp), 32'(er), "read response");
    endtask

    // f is {nine, standby, diode two, diode one}; ev is {diode two, diode one}
    task automatic meas(input logic cd, input logic [3:0] f, input logic [7:0] t, input logic [1:0] ev);
        conversion_done <= cd;
        temperature_sample <= t;
        {analog_input_nine_out_of_limit, standby_supply_out_of_limit} <= f[3:2];
        {remote_diode_two_out_of_limit, remote_diode_one_out_of_limit} <= f[1:0];
        {remote_diode_two_override_event, remote_diode_one_override_event} <= ev;
        @(posedge aclk);
        conversion_done <= 1'b0;
        {remote_diode_two_override_event, remote_diode_one_override_event} <= 2'h0;
        @(posedge aclk);
    endtask

    task automatic summarize;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        $display("MISMATCH %0t watchdog ran out", $time);
        summarize;
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        {conversion_done, temperature_sample} = 9'h000;
        {remote_diode_one_out_of_limit, remote_diode_two_out_of_limit} = 2'h0;
        {analog_input_nine_out_of_limit, standby_supply_out_of_limit} = 2'h0;
        {remote_diode_one_override_event, remote_diode_two_override_event} = 2'h0;
        error_cnt = 0;
        comparisons = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(8'h20, 8'h00, lsr_pkg::RESP_OKAY);
        axi_read(8'h24, 8'h00, lsr_pkg::RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            meas(1'b1, 4'(i), 8'(i * 37 + 15), 2'h0);
            axi_read(8'h20, 8'(i), lsr_pkg::RESP_OKAY);
            axi_read(8'h24, 8'(i * 37 + 15), lsr_pkg::RESP_OKAY);
        end
        for (int i = 0; i < 2; i++) begin
            meas(1'b1, 4'h0, 8'h00, 2'h0);
            meas(1'b0, 4'h0, 8'h00, 2'(1 << i));
            axi_read(8'h20, 8'(1 << i), lsr_pkg::RESP_OKAY);
            axi_read(8'h20, 8'(1 << i), lsr_pkg::RESP_OKAY);
            meas(1'b1, 4'h0, 8'h00, 2'h0);
            axi_read(8'h20, 8'h00, lsr_pkg::RESP_OKAY);
            meas(1'b0, 4'h0, 8'h00, 2'(1 << i));
            axi_read(8'h20, 8'(1 << i), lsr_pkg::RESP_OKAY);
            meas(1'b1, 4'h0, 8'h00, 2'(1 << i));
            axi_read(8'h20, 8'(1 << i), lsr_pkg::RESP_OKAY);
        end
        // voltage measurement mode swaps the source of bit 1
        axi_write(8'h28, 8'h01, lsr_pkg::RESP_OKAY);
        axi_read(8'h28, 8'h01, lsr_pkg::RESP_OKAY);
        check(32'(voltage_mode), 32'h1, "voltage mode");
        meas(1'b1, 4'h8, 8'h00, 2'h0);
        axi_read(8'h20, 8'h02, lsr_pkg::RESP_OKAY);
        meas(1'b1, 4'h2, 8'h00, 2'h0);
        axi_read(8'h20, 8'h00, lsr_pkg::RESP_OKAY);
        axi_write(8'h28, 8'h00, lsr_pkg::RESP_OKAY);
        // refused accesses leave the registers untouched
        meas(1'b1, 4'h5, 8'h3c, 2'h0);
        axi_write(8'h20, 8'hff, lsr_pkg::RESP_SLVERR, 3);
        axi_write(8'h24, 8'hff, lsr_pkg::RESP_SLVERR);
        axi_read(8'h20, 8'h05, lsr_pkg::RESP_OKAY, 2);
        axi_read(8'h24, 8'h3c, lsr_pkg::RESP_OKAY);
        axi_read(8'h30, 8'h00, lsr_pkg::RESP_DECERR);
        axi_read(8'h21, 8'h00, lsr_pkg::RESP_DECERR);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(8'h20, 8'h00, lsr_pkg::RESP_OKAY);
        axi_read(8'h24, 8'h00, lsr_pkg::RESP_OKAY);
        summarize;
    end
endmodule
